/* File: logic/cal_core.sv */
`timescale 1ns/10ps
module cal_core (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic opValid,
	input wire cal_pkg::cal_op_type opCode,
	input wire logic [7:0] srcD,
	input wire logic [7:0] srcR,
	input wire logic [7:0] immK,
	input wire logic [15:0] pairIn,
	input wire logic [15:0] pointerZ,
	input wire logic [15:0] jumpAddr,
	input wire logic [11:0] relOffset,
	input wire logic nextTwoWord,
	input wire logic [15:0] stackTop,
	output logic opReady,
	output logic opDone,
	output logic destWrite,
	output logic [7:0] destData,
	output logic pairWrite,
	output logic [15:0] pairData,
	output logic productWrite,
	output logic [15:0] productData,
	output logic [7:0] statusReg,
	output logic [15:0] progCounter,
	output logic pushWrite,
	output logic [15:0] pushData,
	output logic popStrobe
);
	import cal_pkg::*;

	cal_dp_if dp();
	cal_alu8 uAlu (
		.dp(dp)
	);
	cal_product uProd (
		.dp(dp)
	);

	cal_state_type st;
	logic [2:0] cnt;
	cal_req_type held;
	cal_req_type cur;
	logic accept;
	logic fire;
	logic [2:0] need;
	logic [15:0] wordRes;
	logic wordV;
	logic wordC;
	logic aluZero;
	logic [15:0] seqPc;
	logic [15:0] relTarget;

	// Operands are used straight from the ports on the issue cycle and from the held copy after.
	always_comb begin
		cur = held;
		if (st == ST_IDLE) begin
			cur.op = opCode;
			cur.d = srcD;
			cur.r = srcR;
			cur.k = immK;
			cur.pair = pairIn;
			cur.ptr = pointerZ;
			cur.addr = jumpAddr;
			cur.rel = relOffset;
			cur.twoWord = nextTwoWord;
			cur.stack = stackTop;
		end
	end

	assign accept = (st == ST_IDLE) && opReady && opValid;
	assign need = cal_cycles(cur);
	assign fire = (accept && need == CYC_SINGLE) || (st == ST_BUSY && cnt == CYC_SINGLE);
	assign aluZero = dp.aluRes == 8'h00;
	assign seqPc = progCounter + PC_STEP;
	assign relTarget = progCounter + {{4{cur.rel[11]}}, cur.rel} + PC_STEP;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st <= ST_IDLE;
			cnt <= 3'h0;
			opReady <= 1'b0;
			held <= '0;
		end else if (accept && need != CYC_SINGLE) begin
			st <= ST_BUSY;
			cnt <= need - CYC_SINGLE;
			opReady <= 1'b0;
			held <= cur;
		end else if (st == ST_BUSY) begin
			cnt <= cnt - CYC_SINGLE;
			if (cnt == CYC_SINGLE) begin
				st <= ST_IDLE;
				opReady <= 1'b1;
			end
		end else begin
			opReady <= 1'b1;
		end
	end

	always_comb begin
		dp.aluKind = ALU_ADD;
		dp.aluA = cur.d;
		dp.aluB = cur.r;
		dp.aluCin = 1'b0;
		case (cur.op)
		add_carry_op: dp.aluCin = statusReg[FLAG_C];
		subtract_registers_op, compare_registers_op: dp.aluKind = ALU_SUB;
		subtract_with_borrow_op, compare_with_borrow_op: begin
			dp.aluKind = ALU_SUB;
			dp.aluCin = statusReg[FLAG_C];
		end
		subtract_constant_op, compare_immediate_op: begin
			dp.aluKind = ALU_SUB;
			dp.aluB = cur.k;
		end
		subtract_constant_with_borrow_op: begin
			dp.aluKind = ALU_SUB;
			dp.aluB = cur.k;
			dp.aluCin = statusReg[FLAG_C];
		end
		and_registers_op: dp.aluKind = ALU_AND;
		zero_minus_check_op: begin
			dp.aluKind = ALU_AND;
			dp.aluB = cur.d;
		end
		and_constant_op: begin
			dp.aluKind = ALU_AND;
			dp.aluB = cur.k;
		end
		clear_masked_bits_op: begin
			dp.aluKind = ALU_AND;
			dp.aluB = ALL_ONES - cur.k;
		end
		or_registers_op: dp.aluKind = ALU_OR;
		or_constant_op, set_masked_bits_op: begin
			dp.aluKind = ALU_OR;
			dp.aluB = cur.k;
		end
		exclusive_or_op: dp.aluKind = ALU_XOR;
		clear_register_op: begin
			dp.aluKind = ALU_XOR;
			dp.aluB = cur.d;
		end
		ones_complement_op: begin
			dp.aluKind = ALU_XOR;
			dp.aluB = ALL_ONES;
		end
		twos_complement_op: begin
			dp.aluKind = ALU_SUB;
			dp.aluA = 8'h00;
			dp.aluB = cur.d;
		end
		increment_op: dp.aluB = 8'h01;
		decrement_op: begin
			dp.aluKind = ALU_SUB;
			dp.aluB = 8'h01;
		end
		default: dp.aluKind = ALU_ADD;
		endcase
	end

	always_comb begin
		dp.prA = cur.d;
		dp.prB = cur.r;
		dp.prSignA = cur.op inside {signed_product_op, mixed_sign_product_op,
			fractional_signed_product_op, fractional_mixed_product_op};
		dp.prSignB = cur.op inside {signed_product_op, fractional_signed_product_op};
		dp.prFrac = cur.op inside {fractional_unsigned_product_op,
			fractional_signed_product_op, fractional_mixed_product_op};
	end

	// The word constant is six bits wide; upper bits of immK are ignored here.
	always_comb begin
		wordRes = cur.pair + {8'h00, cur.k & WORD_K_MASK};
		wordV = ~cur.pair[15] & wordRes[15];
		wordC = ~wordRes[15] & cur.pair[15];
		if (cur.op == word_subtract_immediate_op) begin
			wordRes = cur.pair - {8'h00, cur.k & WORD_K_MASK};
			wordV = cur.pair[15] & ~wordRes[15];
			wordC = wordRes[15] & ~cur.pair[15];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			statusReg <= SREG_RESET;
		end else if (fire) begin
			case (cur.op)
			add_registers_op, add_carry_op, subtract_registers_op, subtract_constant_op,
			twos_complement_op, compare_registers_op, compare_immediate_op: begin
				statusReg[FLAG_Z] <= aluZero;
				statusReg[FLAG_C] <= dp.aluC;
				statusReg[FLAG_N] <= dp.aluRes[7];
				statusReg[FLAG_V] <= dp.aluV;
				statusReg[FLAG_S] <= dp.aluRes[7] ^ dp.aluV;
				statusReg[FLAG_H] <= dp.aluH;
			end
			// Borrow forms keep Z only if it was already set, so chains test whole numbers.
			subtract_with_borrow_op, subtract_constant_with_borrow_op,
			compare_with_borrow_op: begin
				statusReg[FLAG_Z] <= aluZero & statusReg[FLAG_Z];
				statusReg[FLAG_C] <= dp.aluC;
				statusReg[FLAG_N] <= dp.aluRes[7];
				statusReg[FLAG_V] <= dp.aluV;
				statusReg[FLAG_S] <= dp.aluRes[7] ^ dp.aluV;
				statusReg[FLAG_H] <= dp.aluH;
			end
			and_registers_op, and_constant_op, or_registers_op, or_constant_op,
			exclusive_or_op, set_masked_bits_op, clear_masked_bits_op, increment_op,
			decrement_op, zero_minus_check_op, clear_register_op: begin
				statusReg[FLAG_Z] <= aluZero;
				statusReg[FLAG_N] <= dp.aluRes[7];
				statusReg[FLAG_V] <= dp.aluV;
				statusReg[FLAG_S] <= dp.aluRes[7] ^ dp.aluV;
			end
			ones_complement_op: begin
				statusReg[FLAG_Z] <= aluZero;
				statusReg[FLAG_C] <= 1'b1;
				statusReg[FLAG_N] <= dp.aluRes[7];
				statusReg[FLAG_V] <= 1'b0;
				statusReg[FLAG_S] <= dp.aluRes[7];
			end
			word_add_immediate_op, word_subtract_immediate_op: begin
				statusReg[FLAG_Z] <= wordRes == 16'h0000;
				statusReg[FLAG_C] <= wordC;
				statusReg[FLAG_N] <= wordRes[15];
				statusReg[FLAG_V] <= wordV;
				statusReg[FLAG_S] <= wordRes[15] ^ wordV;
			end
			unsigned_product_op, signed_product_op, mixed_sign_product_op,
			fractional_unsigned_product_op, fractional_signed_product_op,
			fractional_mixed_product_op: begin
				statusReg[FLAG_Z] <= dp.prRes == 16'h0000;
				statusReg[FLAG_C] <= dp.prCarry;
			end
			interrupt_return_op: statusReg[FLAG_I] <= 1'b1;
			default: statusReg <= statusReg;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			opDone <= 1'b0;
			destWrite <= 1'b0;
			destData <= 8'h00;
			pairWrite <= 1'b0;
			pairData <= 16'h0000;
			productWrite <= 1'b0;
			productData <= 16'h0000;
		end else begin
			opDone <= fire;
			// Compares share the ALU but never write a register back; the test rewrites its own value.
			destWrite <= fire && (cur.op <= fill_ones_op) && !(cur.op inside
				{word_add_immediate_op, word_subtract_immediate_op});
			pairWrite <= fire && (cur.op inside
				{word_add_immediate_op, word_subtract_immediate_op});
			productWrite <= fire && (cur.op inside {unsigned_product_op, signed_product_op,
				mixed_sign_product_op, fractional_unsigned_product_op,
				fractional_signed_product_op, fractional_mixed_product_op});
			if (fire) begin
				destData <= (cur.op == fill_ones_op) ? ALL_ONES : dp.aluRes;
				pairData <= wordRes;
				productData <= dp.prRes;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			progCounter <= PC_RESET;
			pushWrite <= 1'b0;
			pushData <= 16'h0000;
			popStrobe <= 1'b0;
		end else begin
			pushWrite <= fire && (cur.op inside
				{relative_call_op, pointer_call_op, absolute_call_op});
			popStrobe <= fire && (cur.op inside
				{subroutine_return_op, interrupt_return_op});
			if (fire) begin
				pushData <= (cur.op == absolute_call_op) ? progCounter + LONG_STEP : seqPc;
				case (cur.op)
				relative_jump_op, relative_call_op: progCounter <= relTarget;
				pointer_jump_op, pointer_call_op: progCounter <= cur.ptr;
				absolute_jump_op, absolute_call_op: progCounter <= cur.addr;
				subroutine_return_op, interrupt_return_op: progCounter <= cur.stack;
				compare_skip_equal_op: begin
					if (cur.d == cur.r)
						progCounter <= progCounter + (cur.twoWord ? SKIP_LONG : SKIP_SHORT);
					else
						progCounter <= seqPc;
				end
				default: progCounter <= seqPc;
				endcase
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	chk_add_sum: assert property (
		accept && opCode == add_registers_op |=> opDone && destWrite &&
		destData == 8'($past(srcD) + $past(srcR)) &&
		statusReg[FLAG_Z] == (destData == 8'h00))
		else $error("add result or zero flag wrong");
	chk_word_add: assert property (
		accept && opCode == word_add_immediate_op |=> !pairWrite ##1
		pairWrite && pairData == $past(pairIn, 2) + {8'h00, $past(immK, 2) & WORD_K_MASK})
		else $error("word add wrong value or timing");
	chk_word_sub: assert property (
		accept && opCode == word_subtract_immediate_op |=> ##1
		pairWrite && pairData == $past(pairIn, 2) - {8'h00, $past(immK, 2) & WORD_K_MASK})
		else $error("word subtract wrong value");
	chk_sub_borrow: assert property (
		accept && opCode == subtract_registers_op |=> destWrite &&
		destData == 8'($past(srcD) - $past(srcR)) &&
		statusReg[FLAG_C] == ($past(srcR) > $past(srcD)))
		else $error("subtract result or carry wrong");
	chk_sub_const: assert property (
		accept && opCode == subtract_constant_op |=> destWrite &&
		destData == 8'($past(srcD) - $past(immK)))
		else $error("subtract constant wrong");
	chk_and_carry: assert property (
		accept && opCode == and_constant_op |=> destData == ($past(srcD) & $past(immK)) &&
		(statusReg & 8'h09) == ($past(statusReg) & 8'h01))
		else $error("and constant touched carry or overflow");
	chk_clear_bits: assert property (
		accept && opCode == clear_masked_bits_op |=> destData == ($past(srcD) & ~$past(immK)))
		else $error("clear bits wrong");
	chk_prod_pair: assert property (
		accept && opCode == unsigned_product_op |=> !productWrite ##1 productWrite &&
		productData == {8'h00, $past(srcD, 2)} * {8'h00, $past(srcR, 2)})
		else $error("unsigned product wrong");
	chk_frac_shift: assert property (
		accept && opCode == fractional_unsigned_product_op |=> ##1
		productData == 16'(({8'h00, $past(srcD, 2)} * {8'h00, $past(srcR, 2)}) << 1))
		else $error("fractional product not shifted");
	chk_ptr_jump: assert property (
		accept && opCode == pointer_jump_op |=> ##1 opDone &&
		progCounter == $past(pointerZ, 2) && statusReg == $past(statusReg, 2))
		else $error("pointer jump wrong");
	chk_ptr_call: assert property (
		accept && opCode == pointer_call_op |=> !opDone [*2] ##1 pushWrite &&
		progCounter == $past(pointerZ, 3) && pushData == $past(progCounter, 3) + PC_STEP)
		else $error("pointer call wrong");
	chk_skip_step: assert property (
		accept && opCode == compare_skip_equal_op && srcD == srcR && !nextTwoWord
		|=> ##1 progCounter == $past(progCounter, 2) + SKIP_SHORT && !destWrite)
		else $error("skip distance wrong");
	chk_cmp_discard: assert property (
		accept && opCode == compare_immediate_op |=> !destWrite &&
		statusReg[FLAG_Z] == ($past(srcD) == $past(immK)))
		else $error("compare wrote result or bad zero");
	chk_rel_jump: assert property (
		accept && opCode == relative_jump_op |=> ##1 progCounter ==
		$past(progCounter, 2) + {{4{$past(relOffset[11], 2)}}, $past(relOffset, 2)} + PC_STEP)
		else $error("relative jump target wrong");
	chk_return_pop: assert property (
		accept && opCode == subroutine_return_op |=> ##3 popStrobe &&
		progCounter == $past(stackTop, 4))
		else $error("return not restored in four cycles");
	chk_inc_carry: assert property (
		accept && opCode == increment_op |=> destData == 8'($past(srcD) + 8'h01) &&
		statusReg[FLAG_C] == $past(statusReg[FLAG_C]))
		else $error("increment changed carry");

	cov_skip_long: cover property (
		accept && opCode == compare_skip_equal_op && srcD == srcR && nextTwoWord);
	cov_call_abs: cover property (accept && opCode == absolute_call_op ##4 pushWrite);
	cov_signed_prod: cover property (accept && opCode == fractional_signed_product_op);
endmodule // cal_core

/* File: logic/cal_pkg.sv */
// Summary of operation
// - Add registers, optionally with carry; write sum; update Z,C,N,V,H; one cycle.
// - Word add of constant to pair; write back; update Z,C,N,V,S; two cycles.
// - Word subtract of constant from pair; write back; update Z,C,N,V,S.
// - Subtract registers, optionally with carry; write result; Z,C,N,V,H; one cycle.
// - Subtract constant from register; write result; Z,C,N,V,H; one cycle.
// - Subtract constant and carry from register; write result; Z,C,N,V,H.
// - AND register with constant; Z,N,V,S only; carry kept; one cycle.
// - OR register with constant; Z,N,V,S only; one cycle.
// - Set masked bits by OR with constant; Z,N,V; one cycle.
// - Clear masked bits by AND with inverted mask; Z,N,V; one cycle.
// - Test ANDs register with itself, value kept; Z,N,V; one cycle.
// - Integer products land in the product pair; only Z,C; two cycles.
// - Fractional products are shifted left once into the pair; Z,C; two cycles.
// - Pointer jump loads the counter from the pointer pair; no flags; two cycles.
// - Pointer call goes to the pointer pair address; no flags; three cycles.
// - Compare-skip changes no flags; when equal skips by two or three.
// - Compare with constant sets Z,N,V,C,H and discards the difference; one cycle.
package cal_pkg;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_I = 7;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] WORD_K_MASK = 8'h3f;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [15:0] LONG_STEP = 16'h0002;
	localparam logic [15:0] SKIP_SHORT = 16'h0002;
	localparam logic [15:0] SKIP_LONG = 16'h0003;
	localparam logic [2:0] CYC_SINGLE = 3'h1;
	localparam logic [2:0] CYC_WORD = 3'h2;
	localparam logic [2:0] CYC_PRODUCT = 3'h2;
	localparam logic [2:0] CYC_REL_JUMP = 3'h2;
	localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
	localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
	localparam logic [2:0] CYC_REL_CALL = 3'h3;
	localparam logic [2:0] CYC_PTR_CALL = 3'h3;
	localparam logic [2:0] CYC_ABS_CALL = 3'h4;
	localparam logic [2:0] CYC_RETURN = 3'h4;
	localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYC_SKIP_LONG = 3'h3;

	typedef enum logic [5:0] {
		add_registers_op, add_carry_op, word_add_immediate_op,
		subtract_registers_op, subtract_constant_op, subtract_with_borrow_op,
		subtract_constant_with_borrow_op, word_subtract_immediate_op,
		and_registers_op, and_constant_op, or_registers_op, or_constant_op,
		exclusive_or_op, ones_complement_op, twos_complement_op,
		set_masked_bits_op, clear_masked_bits_op, increment_op, decrement_op,
		zero_minus_check_op, clear_register_op, fill_ones_op,
		unsigned_product_op, signed_product_op, mixed_sign_product_op,
		fractional_unsigned_product_op, fractional_signed_product_op,
		fractional_mixed_product_op,
		relative_jump_op, pointer_jump_op, absolute_jump_op,
		relative_call_op, pointer_call_op, absolute_call_op,
		subroutine_return_op, interrupt_return_op,
		compare_skip_equal_op, compare_registers_op, compare_with_borrow_op,
		compare_immediate_op
	} cal_op_type;

	typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR} cal_alu_type;

	typedef enum logic {ST_IDLE, ST_BUSY} cal_state_type;

	typedef struct packed {
		cal_op_type op;
		logic [7:0] d;
		logic [7:0] r;
		logic [7:0] k;
		logic [15:0] pair;
		logic [15:0] ptr;
		logic [15:0] addr;
		logic [11:0] rel;
		logic twoWord;
		logic [15:0] stack;
	} cal_req_type;

	function automatic logic [2:0] cal_cycles(input cal_req_type q);
		logic [2:0] n;
		n = CYC_SINGLE;
		case (q.op)
		word_add_immediate_op, word_subtract_immediate_op: n = CYC_WORD;
		unsigned_product_op, signed_product_op, mixed_sign_product_op,
		fractional_unsigned_product_op, fractional_signed_product_op,
		fractional_mixed_product_op: n = CYC_PRODUCT;
		relative_jump_op: n = CYC_REL_JUMP;
		pointer_jump_op: n = CYC_PTR_JUMP;
		absolute_jump_op: n = CYC_ABS_JUMP;
		relative_call_op: n = CYC_REL_CALL;
		pointer_call_op: n = CYC_PTR_CALL;
		absolute_call_op: n = CYC_ABS_CALL;
		subroutine_return_op, interrupt_return_op: n = CYC_RETURN;
		compare_skip_equal_op: begin
			if (q.d == q.r)
				n = q.twoWord ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
		end
		default: n = CYC_SINGLE;
		endcase
		return n;
	endfunction
endpackage

/* File: logic/cal_dp_if.sv */
`timescale 1ns/10ps
interface cal_dp_if;
	import cal_pkg::*;
	cal_alu_type aluKind;
	logic [7:0] aluA;
	logic [7:0] aluB;
	logic aluCin;
	logic [7:0] aluRes;
	logic aluC;
	logic aluH;
	logic aluV;
	logic [7:0] prA;
	logic [7:0] prB;
	logic prSignA;
	logic prSignB;
	logic prFrac;
	logic [15:0] prRes;
	logic prCarry;
	modport core(output aluKind, aluA, aluB, aluCin, prA, prB, prSignA, prSignB, prFrac,
		input aluRes, aluC, aluH, aluV, prRes, prCarry);
	modport alu(input aluKind, aluA, aluB, aluCin, output aluRes, aluC, aluH, aluV);
	modport prod(input prA, prB, prSignA, prSignB, prFrac, output prRes, prCarry);
endinterface

/* File: logic/cal_alu8.sv */
`timescale 1ns/10ps
module cal_alu8 (
	cal_dp_if.alu dp
);
	import cal_pkg::*;
	logic [8:0] wide;
	logic [4:0] low;

	// Subtraction borrows come out as carry, which is what the flag wants.
	always_comb begin
		wide = 9'h000;
		low = 5'h00;
		dp.aluV = 1'b0;
		case (dp.aluKind)
		ALU_ADD: begin
			wide = {1'b0, dp.aluA} + {1'b0, dp.aluB} + {8'h00, dp.aluCin};
			low = {1'b0, dp.aluA[3:0]} + {1'b0, dp.aluB[3:0]} + {4'h0, dp.aluCin};
			dp.aluV = (dp.aluA[7] == dp.aluB[7]) && (wide[7] != dp.aluA[7]);
		end
		ALU_SUB: begin
			wide = {1'b0, dp.aluA} - {1'b0, dp.aluB} - {8'h00, dp.aluCin};
			low = {1'b0, dp.aluA[3:0]} - {1'b0, dp.aluB[3:0]} - {4'h0, dp.aluCin};
			dp.aluV = (dp.aluA[7] != dp.aluB[7]) && (wide[7] != dp.aluA[7]);
		end
		ALU_AND: wide = {1'b0, dp.aluA & dp.aluB};
		ALU_OR: wide = {1'b0, dp.aluA | dp.aluB};
		ALU_XOR: wide = {1'b0, dp.aluA ^ dp.aluB};
		default: wide = 9'h000;
		endcase
		dp.aluRes = wide[7:0];
		dp.aluC = wide[8];
		dp.aluH = low[4];
	end
endmodule // cal_alu8

/* File: logic/cal_product.sv */
`timescale 1ns/10ps
module cal_product (
	cal_dp_if.prod dp
);
	import cal_pkg::*;
	logic signed [8:0] opA;
	logic signed [8:0] opB;
	logic signed [17:0] full;

	// A ninth bit makes one signed multiplier serve all three sign mixes.
	always_comb begin
		opA = {dp.prSignA & dp.prA[7], dp.prA};
		opB = {dp.prSignB & dp.prB[7], dp.prB};
		full = opA * opB;
		dp.prCarry = full[15];
		dp.prRes = dp.prFrac ? {full[14:0], 1'b0} : full[15:0];
	end
endmodule // cal_product

/* File: test/cal_issuer.sv */
`timescale 1ns/10ps
module cal_issuer (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic go,
	input wire cal_pkg::cal_req_type req,
	input wire logic opReady,
	output logic opValid,
	output cal_pkg::cal_req_type reqOut
);
	import cal_pkg::*;
	cal_req_type held;
	// A request is held whole until the core takes it.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			opValid <= 1'b0;
			held <= '0;
		end else if (go && !opValid) begin
			opValid <= 1'b1;
			held <= req;
		end else if (opValid && opReady) begin
			opValid <= 1'b0;
		end
	end
	// Idle lines show the inverse so that a stale operand never passes for a fresh one.
	assign reqOut = opValid ? held : ~held;
endmodule // cal_issuer

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb;
	import cal_pkg::*;
	logic mclk, sys_rst, go, opValid, opReady, opDone, destWrite, pairWrite, productWrite;
	logic pushWrite, popStrobe;
	logic [7:0] destData, statusReg;
	logic [15:0] pairData, productData, progCounter, pushData, pc;
	logic [4:0] seen;
	cal_req_type rq, bus;
	int err_count, n_tests, cyc, tick;
	cal_issuer issuer_u (.mclk(mclk), .sys_rst(sys_rst), .go(go), .req(rq), .opReady(opReady),
		.opValid(opValid), .reqOut(bus));
	cal_core dut_u (.mclk(mclk), .sys_rst(sys_rst), .opValid(opValid), .opCode(bus.op),
		.srcD(bus.d), .srcR(bus.r), .immK(bus.k), .pairIn(bus.pair), .pointerZ(bus.ptr),
		.jumpAddr(bus.addr), .relOffset(bus.rel), .nextTwoWord(bus.twoWord),
		.stackTop(bus.stack), .opReady(opReady), .opDone(opDone), .destWrite(destWrite),
		.destData(destData), .pairWrite(pairWrite), .pairData(pairData),
		.productWrite(productWrite), .productData(productData), .statusReg(statusReg),
		.progCounter(progCounter), .pushWrite(pushWrite), .pushData(pushData),
		.popStrobe(popStrobe));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Latency is counted from the edge that takes the request.
	always @(posedge mclk) begin
		cyc <= (opValid && opReady) ? 1 : cyc + 1;
		tick <= tick + 1;
		if (tick == 3000) begin
			err_count++;
			summarize();
		end
	end
	task automatic summarize();
		if (err_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input int n);
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		for (int i = 0; i < 20 && opDone !== 1'b1; i++) begin
			@(posedge mclk);
			#1;
		end
		cmp("cycles", 16'(n), 16'(cyc));
		seen = {destWrite, pairWrite, productWrite, pushWrite, popStrobe};
		pc = pc + 16'h1;
	endtask
	task automatic setop(input cal_op_type o, input logic [7:0] d, r, k);
		rq.op = o;
		rq.d = d;
		rq.r = r;
		rq.k = k;
	endtask
	task automatic bop(input cal_op_type o, input logic [7:0] d, k, res, m, f, input logic wr);
		setop(o, d, k, k);
		run(1);
		cmp("destWrite", 16'(wr), 16'(seen[4]));
		if (wr) cmp("destData", 16'(res), 16'(destData));
		cmp("flags", 16'(f & m), 16'(statusReg & m));
		cmp("pc", pc, progCounter);
	endtask
	task automatic wop(input cal_op_type o, input logic [15:0] p, res, input logic [7:0] f);
		setop(o, 8'h00, 8'h00, 8'hc1);
		rq.pair = p;
		run(2);
		cmp("pairWrite", 16'h1, 16'(seen[3]));
		cmp("pairData", res, pairData);
		cmp("flags", 16'(f), 16'(statusReg & 8'h1f));
	endtask
	task automatic mop(input cal_op_type o, input logic [7:0] d, r, input logic [15:0] res,
		input logic [7:0] f);
		setop(o, d, r, 8'h00);
		run(2);
		cmp("productWrite", 16'h1, 16'(seen[2]));
		cmp("productData", res, productData);
		cmp("flags", 16'(f), 16'(statusReg & 8'h03));
	endtask
	task automatic fop(input cal_op_type o, input int n, input logic [15:0] npc, input logic psh);
		logic [7:0] s;
		logic [15:0] ret;
		s = statusReg;
		ret = pc + ((o == absolute_call_op) ? 16'h2 : 16'h1);
		rq.op = o;
		run(n);
		cmp("pc", npc, progCounter);
		cmp("flags", 16'(s & 8'h7f), 16'(statusReg & 8'h7f));
		cmp("pushWrite", 16'(psh), 16'(seen[1]));
		if (psh) cmp("pushData", ret, pushData);
		cmp("pop", 16'(o inside {subroutine_return_op, interrupt_return_op}), 16'(seen[0]));
		pc = npc;
	endtask
	task automatic byte_ops();
		bop(add_registers_op, 8'h7f, 8'h01, 8'h80, 8'h2f, 8'h2c, 1);
		bop(subtract_registers_op, 8'h00, 8'h01, 8'hff, 8'h2f, 8'h25, 1);
		bop(add_carry_op, 8'h01, 8'h01, 8'h03, 8'h2f, 8'h00, 1);
		bop(subtract_constant_op, 8'h10, 8'h01, 8'h0f, 8'h2f, 8'h20, 1);
		bop(subtract_with_borrow_op, 8'h00, 8'h00, 8'h00, 8'h2f, 8'h00, 1);
		bop(subtract_registers_op, 8'h00, 8'h01, 8'hff, 8'h2f, 8'h25, 1);
		bop(subtract_constant_with_borrow_op, 8'h05, 8'h02, 8'h02, 8'h2f, 8'h00, 1);
		bop(subtract_registers_op, 8'h00, 8'h01, 8'hff, 8'h2f, 8'h25, 1);
		bop(and_constant_op, 8'hff, 8'h00, 8'h00, 8'h0f, 8'h03, 1);
		bop(or_constant_op, 8'h00, 8'h81, 8'h81, 8'h0e, 8'h04, 1);
		bop(set_masked_bits_op, 8'h10, 8'h01, 8'h11, 8'h0e, 8'h00, 1);
		bop(clear_masked_bits_op, 8'hf0, 8'hf0, 8'h00, 8'h0e, 8'h02, 1);
		bop(zero_minus_check_op, 8'h80, 8'h80, 8'h80, 8'h0e, 8'h04, 1);
		bop(compare_immediate_op, 8'h05, 8'h06, 8'h00, 8'h2f, 8'h25, 0);
		bop(ones_complement_op, 8'h0f, 8'h00, 8'hf0, 8'h0f, 8'h05, 1);
		bop(increment_op, 8'h7f, 8'h00, 8'h80, 8'h0f, 8'h0d, 1);
		bop(twos_complement_op, 8'h01, 8'h00, 8'hff, 8'h2f, 8'h25, 1);
		bop(and_registers_op, 8'h3c, 8'h0f, 8'h0c, 8'h0e, 8'h00, 1);
		bop(or_registers_op, 8'h00, 8'h00, 8'h00, 8'h0e, 8'h02, 1);
		bop(exclusive_or_op, 8'hff, 8'h0f, 8'hf0, 8'h0e, 8'h04, 1);
		bop(clear_register_op, 8'ha5, 8'h00, 8'h00, 8'h0e, 8'h02, 1);
		bop(decrement_op, 8'h80, 8'h00, 8'h7f, 8'h0f, 8'h09, 1);
		bop(fill_ones_op, 8'h12, 8'h00, 8'hff, 8'h2f, 8'h29, 1);
		bop(compare_registers_op, 8'h10, 8'h10, 8'h00, 8'h2f, 8'h02, 0);
		bop(compare_with_borrow_op, 8'h10, 8'h10, 8'h00, 8'h2f, 8'h02, 0);
	endtask
	task automatic word_and_products();
		wop(word_add_immediate_op, 16'hffff, 16'h0000, 8'h03);
		wop(word_subtract_immediate_op, 16'h0000, 16'hffff, 8'h15);
		wop(word_add_immediate_op, 16'h7fff, 16'h8000, 8'h0c);
		mop(unsigned_product_op, 8'hff, 8'hff, 16'hfe01, 8'h01);
		mop(unsigned_product_op, 8'h00, 8'h12, 16'h0000, 8'h02);
		mop(signed_product_op, 8'hff, 8'hff, 16'h0001, 8'h00);
		mop(mixed_sign_product_op, 8'hff, 8'hff, 16'hff01, 8'h01);
		mop(fractional_unsigned_product_op, 8'h80, 8'h80, 16'h8000, 8'h00);
		mop(fractional_signed_product_op, 8'h80, 8'h80, 16'h8000, 8'h00);
		mop(fractional_mixed_product_op, 8'h80, 8'h80, 16'h8000, 8'h01);
	endtask
	task automatic flow_ops();
		rq.rel = 12'hffe;
		fop(relative_jump_op, 2, pc - 16'h1, 0);
		rq.rel = 12'h010;
		fop(relative_call_op, 3, pc + 16'h11, 1);
		rq.addr = 16'h1234;
		fop(absolute_jump_op, 3, 16'h1234, 0);
		rq.addr = 16'h2000;
		fop(absolute_call_op, 4, 16'h2000, 1);
		rq.ptr = 16'h0abc;
		fop(pointer_jump_op, 2, 16'h0abc, 0);
		rq.ptr = 16'h0100;
		fop(pointer_call_op, 3, 16'h0100, 1);
		rq.stack = 16'h0456;
		fop(subroutine_return_op, 4, 16'h0456, 0);
		rq.stack = 16'h0777;
		fop(interrupt_return_op, 4, 16'h0777, 0);
		setop(compare_skip_equal_op, 8'h5a, 8'h5a, 8'h00);
		rq.twoWord = 1'b1;
		fop(compare_skip_equal_op, 3, pc + 16'h3, 0);
		rq.twoWord = 1'b0;
		fop(compare_skip_equal_op, 2, pc + 16'h2, 0);
		rq.r = 8'h5b;
		fop(compare_skip_equal_op, 1, pc + 16'h1, 0);
	endtask
	initial begin
		go = 1'b0;
		sys_rst = 1'b1;
		rq = '0;
		pc = 16'h0;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		#1;
		cmp("resetPc", 16'h0, progCounter);
		cmp("resetFlags", 16'h0, 16'(statusReg));
		byte_ops();
		word_and_products();
		flow_ops();
		summarize();
	end
endmodule // tb
